// File: design/pwm_fpt_pkg.sv
/*
 pwm_fpt_pkg: register offsets, field positions, reset values and widths
 shared by the pwm fault, phase and trigger block and its fault filter.
 assumes a 32-bit apb slave with one register per aligned word.
*/
package pwm_fpt_pkg;
    localparam int          NUM_SUB       = 4;
    localparam int          CNT_W         = 16;
    localparam int          PER_W         = 8;
    localparam int          SCNT_W        = 3;
    localparam int          PRSC_W        = 3;
    // register byte offsets
    localparam logic [11:0] OFS_CTRL      = 12'h000;
    localparam logic [11:0] OFS_FILT      = 12'h004;
    localparam logic [11:0] OFS_PERIOD    = 12'h008;
    localparam logic [11:0] OFS_STATUS    = 12'h00C;
    localparam logic [11:0] OFS_SUB_BASE  = 12'h010;
    localparam logic [11:0] OFS_SUB_STEP  = 12'h010;
    localparam logic [3:0]  SUB_PHASE     = 4'h0;
    localparam logic [3:0]  SUB_CMPA      = 4'h4;
    localparam logic [3:0]  SUB_CMPB      = 4'h8;
    localparam logic [3:0]  SUB_ROUTE     = 4'hC;
    // control, filter and status fields
    localparam int          CTRL_RUN      = 0;
    localparam int          CTRL_RELSEL   = 1;
    localparam int          CTRL_NONCOMB  = 2;
    localparam int          CTRL_STRETCH  = 3;
    localparam int          CTRL_PRSC_LO  = 4;
    localparam int          FILT_COUNT_LO = 8;
    localparam int          STAT_FAULT    = 0;
    localparam int          STAT_FILT     = 1;
    localparam int          STAT_PWM_LO   = 4;
    // trigger route sources
    localparam logic [1:0]  SRC_CMPA      = 2'h0;
    localparam logic [1:0]  SRC_CMPB      = 2'h1;
    localparam logic [1:0]  SRC_INIT      = 2'h2;
    localparam logic [1:0]  SRC_PEND      = 2'h3;
    // reset values
    localparam logic [31:0] RST_CTRL      = 32'h0000_0000;
    localparam logic [CNT_W-1:0] RST_PERIOD = 16'h00FF;
    // filter: samples needed beyond the programmed count
    localparam int          FILT_EXTRA    = 3;
endpackage : pwm_fpt_pkg

// File: design/pwm_fault_filter.sv
/*
 pwm_fault_filter: samples the fault input every sample period and accepts
 a level change after count plus three equal samples; zero period passes
 the input through one flop. assumes a synchronous fault input.
*/
`timescale 1ns/1ns
module pwm_fault_filter
    import pwm_fpt_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              faultIn,
    input  wire logic [PER_W-1:0]  samplePeriod,
    input  wire logic [SCNT_W-1:0] sampleCount,
    output logic                   faultOut
);
    logic [PER_W-1:0]  tickCnt_r;
    logic [SCNT_W+1:0] sameCnt_r;
    logic              out_r;
    logic              tick;

    assign tick     = (tickCnt_r == samplePeriod - 8'h01);
    assign faultOut = out_r;

    always_ff @(posedge clk) begin
        if (rst || tick || samplePeriod == '0) begin
            tickCnt_r <= '0;
        end else begin
            tickCnt_r <= tickCnt_r + 8'h01;
        end
    end

    // consecutive differing samples before the level is taken
    always_ff @(posedge clk) begin
        if (rst) begin
            out_r     <= 1'b0;
            sameCnt_r <= '0;
        end else if (samplePeriod == '0) begin
            out_r     <= faultIn;
            sameCnt_r <= '0;
        end else if (tick) begin
            if (faultIn == out_r) begin
                sameCnt_r <= '0;
            end else if (sameCnt_r ==
                         {2'b00, sampleCount} + 5'(FILT_EXTRA - 1)) begin
                out_r     <= faultIn;
                sameCnt_r <= '0;
            end else begin
                sameCnt_r <= sameCnt_r + 5'h01;
            end
        end
    end

    a_bypass_follow: assert property (@(posedge clk) disable iff (rst)
        samplePeriod == '0 && $past(samplePeriod) == '0
        |-> faultOut == $past(faultIn))
        else $error("filter bypass does not follow input");
    a_filter_steady: assert property (@(posedge clk) disable iff (rst)
        samplePeriod != '0 && !tick |=> $stable(faultOut))
        else $error("filter output moved off a sample tick");
endmodule : pwm_fault_filter

// File: design/pwm_fault_phase_trigger.sv
/*
 pwm_fault_phase_trigger: four pwm submodules with phase delay against
 submodule 0, fault protection with filter and glitch stretch, and
 stretched output triggers; registers over apb.
 assumes fault input and apb signals synchronous to clk.
*/
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ns
module pwm_fault_phase_trigger
    import pwm_fpt_pkg::*;
#(
    parameter int NSUB = NUM_SUB
)(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             faultIn,
    output logic      [NSUB-1:0]  pwmOut,
    output logic      [NSUB-1:0]  triggerOutZero,
    output logic      [NSUB-1:0]  triggerOutOne
);
    logic [31:0]      ctrl_r;
    logic [PER_W-1:0] filtPer_r;
    logic [SCNT_W-1:0] filtCnt_r;
    logic [CNT_W-1:0] period_r;
    logic [CNT_W-1:0] cnt0_r;
    logic [CNT_W-1:0] phaseDly_r  [NSUB];
    logic [CNT_W-1:0] phaseAct_r  [NSUB];
    logic [CNT_W-1:0] cmpA_r      [NSUB];
    logic [CNT_W-1:0] cmpB_r      [NSUB];
    logic [3:0]       route_r     [NSUB];
    logic [CNT_W-1:0] smCnt       [NSUB];
    logic [NSUB-1:0]  pwmRaw_r;
    logic             faultLatch_r;
    logic             filtOut;
    logic             filtPrev_r;
    logic             faultSeen;
    logic             faultBlock;
    logic             periodEnd;
    logic             wrEn;
    logic             rdEn;
    logic             clrFault;
    logic             mapped;
    logic [31:0]      rdData;
    logic [PRSC_W-1:0] prsc;

    assign prsc      = ctrl_r[CTRL_PRSC_LO +: PRSC_W];
    assign periodEnd = (cnt0_r == period_r);
    assign wrEn      = psel && penable && pwrite;
    assign rdEn      = psel && !penable && !pwrite;
    assign pready    = 1'b1;

    // ---------------- apb register file ----------------
    always_comb begin
        mapped = 1'b1;
        rdData = 32'h0000_0000;
        unique case (paddr)
            OFS_CTRL:   rdData = ctrl_r;
            OFS_FILT:   rdData = {21'h0, filtCnt_r, filtPer_r};
            OFS_PERIOD: rdData = {16'h0000, period_r};
            OFS_STATUS: rdData = {24'h0, pwmOut, 2'b00, filtOut,
                                  faultLatch_r};
            default:    mapped = 1'b0;
        endcase
        for (int i = 0; i < NSUB; i++) begin
            if (paddr[11:4] == OFS_SUB_BASE[11:4] + 8'(i)) begin
                mapped = 1'b1;
                unique case (paddr[3:0])
                    SUB_PHASE: rdData = {16'h0000, phaseDly_r[i]};
                    SUB_CMPA:  rdData = {16'h0000, cmpA_r[i]};
                    SUB_CMPB:  rdData = {16'h0000, cmpB_r[i]};
                    SUB_ROUTE: rdData = {28'h0, route_r[i]};
                    default:   mapped = 1'b0;
                endcase
            end
        end
    end

    assign pslverr  = psel && penable && !mapped;
    assign clrFault = wrEn && paddr == OFS_STATUS && pwdata[STAT_FAULT];

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (rdEn) begin
            prdata <= rdData;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r    <= RST_CTRL;
            filtPer_r <= '0;
            filtCnt_r <= '0;
            period_r  <= RST_PERIOD;
        end else if (wrEn) begin
            if (paddr == OFS_CTRL) begin
                ctrl_r <= {24'h0, 1'b0, pwdata[6:0]};
            end
            if (paddr == OFS_FILT) begin
                filtPer_r <= pwdata[PER_W-1:0];
                filtCnt_r <= pwdata[FILT_COUNT_LO +: SCNT_W];
            end
            if (paddr == OFS_PERIOD) begin
                period_r <= pwdata[CNT_W-1:0];
            end
        end
    end

    // ---------------- master counter ----------------
    always_ff @(posedge clk) begin
        if (rst || !ctrl_r[CTRL_RUN] || periodEnd) begin
            cnt0_r <= '0;
        end else begin
            cnt0_r <= cnt0_r + 16'h0001;
        end
    end

    // ---------------- per submodule ----------------
    genvar g;
    generate
        for (g = 0; g < NSUB; g++) begin : gSub
            logic [11:0]      base;
            logic             srcHit0;
            logic             srcHit1;
            logic [6:0]       hold0_r;
            logic [6:0]       hold1_r;
            assign base = OFS_SUB_BASE + 12'(g * 16);

            always_ff @(posedge clk) begin
                if (rst) begin
                    phaseDly_r[g] <= '0;
                    cmpA_r[g]     <= '0;
                    cmpB_r[g]     <= '0;
                    route_r[g]    <= '0;
                end else if (wrEn && paddr[11:4] == base[11:4]) begin
                    if (paddr[3:0] == SUB_PHASE && g != 0) begin
                        phaseDly_r[g] <= pwdata[CNT_W-1:0];
                    end
                    if (paddr[3:0] == SUB_CMPA) begin
                        cmpA_r[g] <= pwdata[CNT_W-1:0];
                    end
                    if (paddr[3:0] == SUB_CMPB) begin
                        cmpB_r[g] <= pwdata[CNT_W-1:0];
                    end
                    if (paddr[3:0] == SUB_ROUTE) begin
                        route_r[g] <= pwdata[3:0];
                    end
                end
            end

            // delay taken only at period end when reload select is set
            always_ff @(posedge clk) begin
                if (rst) begin
                    phaseAct_r[g] <= '0;
                end else if (!ctrl_r[CTRL_RELSEL] || periodEnd) begin
                    phaseAct_r[g] <= phaseDly_r[g];
                end
            end

            // offset counter wraps inside the period, so a delay of zero
            // never stretches a cycle of the output
            always_comb begin
                if (cnt0_r >= phaseAct_r[g]) begin
                    smCnt[g] = cnt0_r - phaseAct_r[g];
                end else begin
                    smCnt[g] = cnt0_r + period_r + 16'h0001 - phaseAct_r[g];
                end
            end

            always_ff @(posedge clk) begin
                if (rst) begin
                    pwmRaw_r[g] <= 1'b0;
                end else begin
                    pwmRaw_r[g] <= ctrl_r[CTRL_RUN] && smCnt[g] >= cmpA_r[g]
                                   && smCnt[g] < cmpB_r[g];
                end
            end

            function automatic logic hit(input logic [1:0] sel);
                logic r;
                r = 1'b0;
                unique case (sel)
                    SRC_CMPA: r = smCnt[g] == cmpA_r[g];
                    SRC_CMPB: r = smCnt[g] == cmpB_r[g];
                    SRC_INIT: r = smCnt[g] == '0;
                    SRC_PEND: r = smCnt[g] == period_r;
                endcase
                return r && ctrl_r[CTRL_RUN];
            endfunction

            assign srcHit0 = hit(route_r[g][1:0]);
            assign srcHit1 = hit(route_r[g][3:2]);

            // width is two to the prescale clocks
            always_ff @(posedge clk) begin
                if (rst) begin
                    hold0_r           <= '0;
                    hold1_r           <= '0;
                    triggerOutZero[g] <= 1'b0;
                    triggerOutOne[g]  <= 1'b0;
                end else begin
                    if (srcHit0) begin
                        hold0_r <= 7'((8'h01 << prsc) - 8'h01);
                    end else if (hold0_r != '0) begin
                        hold0_r <= hold0_r - 7'h01;
                    end
                    if (srcHit1) begin
                        hold1_r <= 7'((8'h01 << prsc) - 8'h01);
                    end else if (hold1_r != '0) begin
                        hold1_r <= hold1_r - 7'h01;
                    end
                    triggerOutZero[g] <= srcHit0 || hold0_r != '0;
                    triggerOutOne[g]  <= srcHit1 || hold1_r != '0;
                end
            end

            a_trig_single: assert property (@(posedge clk) disable iff (rst)
                prsc == '0 && $rose(triggerOutZero[g]) && !srcHit0
                |=> !triggerOutZero[g])
                else $error("unstretched trigger wider than one clock");
            a_trig_stretch: assert property (@(posedge clk) disable iff (rst)
                prsc == 3'd2 && $stable(prsc) && srcHit1
                |=> triggerOutOne[g] [*4])
                else $error("stretched trigger shorter than four clocks");
            a_route_cmpa: assert property (@(posedge clk) disable iff (rst)
                route_r[g][1:0] == SRC_CMPA && ctrl_r[CTRL_RUN]
                && smCnt[g] == cmpA_r[g] |=> triggerOutZero[g])
                else $error("routed compare match gave no trigger");
            a_phase_hold: assert property (@(posedge clk) disable iff (rst)
                ctrl_r[CTRL_RELSEL] && !periodEnd |=> $stable(phaseAct_r[g]))
                else $error("phase delay taken before period end");
        end
    endgenerate

    // ---------------- fault protection ----------------
    pwm_fault_filter uFilter (
        .clk          (clk),
        .rst          (rst),
        .faultIn      (faultIn),
        .samplePeriod (filtPer_r),
        .sampleCount  (filtCnt_r),
        .faultOut     (filtOut)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            filtPrev_r <= 1'b0;
        end else begin
            filtPrev_r <= filtOut;
        end
    end

    // glitch stretch widens the filtered fault by one clock
    assign faultSeen = filtOut || (ctrl_r[CTRL_STRETCH] && filtPrev_r)
                       || (!ctrl_r[CTRL_NONCOMB] && faultIn);

    // sticky until cleared with the fault gone; a new fault wins the clear
    always_ff @(posedge clk) begin
        if (rst) begin
            faultLatch_r <= 1'b0;
        end else if (faultSeen) begin
            faultLatch_r <= 1'b1;
        end else if (clrFault) begin
            faultLatch_r <= 1'b0;
        end
    end

    // combinational path blocks at once, latch keeps outputs quiet
    assign faultBlock = faultLatch_r || (!ctrl_r[CTRL_NONCOMB] && faultIn);
    assign pwmOut     = faultBlock ? '0 : pwmRaw_r;

    a_fault_quiet: assert property (@(posedge clk) disable iff (rst)
        faultLatch_r && !clrFault |=> pwmOut == '0 && faultLatch_r)
        else $error("outputs left inactive state while faulted");
    a_comb_block: assert property (@(posedge clk) disable iff (rst)
        !ctrl_r[CTRL_NONCOMB] && faultIn |-> pwmOut == '0 ##1 faultLatch_r)
        else $error("combinational fault did not block outputs");
    a_fault_setwins: assert property (@(posedge clk) disable iff (rst)
        clrFault && faultSeen |=> faultLatch_r)
        else $error("fault lost to a simultaneous clear");

    c_fault_clear: cover property (@(posedge clk) disable iff (rst)
        faultLatch_r ##1 !faultLatch_r);
    c_trig_stretch: cover property (@(posedge clk) disable iff (rst)
        prsc != '0 && $rose(triggerOutZero[1]));
    c_phase_zero: cover property (@(posedge clk) disable iff (rst)
        phaseAct_r[1] != '0 ##1 phaseAct_r[1] == '0);
endmodule : pwm_fault_phase_trigger

// File: dv/pwm_trig_fault_partner.sv
/*
 pwm_trig_fault_partner: fault source and trigger consumer beside the pwm
 block. assumes clk is the pwm clock and triggers are active high.
*/
`timescale 1ns/1ns
module pwm_trig_fault_partner (
    input  wire logic       clk,
    input  wire logic [3:0] trigZero,
    input  wire logic [3:0] trigOne,
    output logic            faultIn
);
    int   cyc       = 0;
    int   riseZero  = 0;
    int   riseOne   = 0;
    int   widthZero = 0;
    int   runZero   = 0;
    logic prevZero  = 1'b0;
    logic prevOne   = 1'b0;

    initial faultIn = 1'b0;

    // records rise times and the width of the last trigger pulse
    always @(posedge clk) begin
        cyc      <= cyc + 1;
        prevZero <= trigZero[0];
        prevOne  <= trigOne[0];
        if (trigZero[0] && !prevZero) riseZero <= cyc;
        if (trigOne[0] && !prevOne) riseOne <= cyc;
        if (trigZero[0]) runZero <= runZero + 1;
        else runZero <= 0;
        if (!trigZero[0] && prevZero) widthZero <= runZero;
    end

    // shortest fault pulse that the filter handles cleanly at the given period and count
    function automatic int legal_width(input bit stretch, input int per,
                                       input int cnt);
        if (per == 0) return stretch ? 4 : 7;
        return per * (cnt + 3) + (stretch ? 6 : 9) + 1;
    endfunction : legal_width

    // fault high for w clocks
    task automatic pulse(input int w);
        @(posedge clk);
        faultIn <= 1'b1;
        repeat (w) @(posedge clk);
        faultIn <= 1'b0;
    endtask : pulse
endmodule : pwm_trig_fault_partner

// File: dv/pwm_fault_phase_trigger_test.sv
/*
 pwm_fault_phase_trigger_test: apb register model, trigger, fault, filter
 and phase checks. assumes the partner model drives the fault input.
*/
`timescale 1ns/1ns
module pwm_fault_phase_trigger_test
    import pwm_fpt_pkg::*;
;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr;
    logic        faultIn, rdErr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdData;
    logic [3:0]  pwmOut, triggerOutZero, triggerOutOne;
    logic [15:0] lfsrState;
    logic [31:0] mdl [int];
    int          fail_count, checks, hi, mr;
    int          cycles  = 0;
    int          offs[4] = '{0, 8, 13, 12};

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    pwm_fault_phase_trigger i_pwm_fault_phase_trigger (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .faultIn(faultIn),
        .pwmOut(pwmOut), .triggerOutZero(triggerOutZero),
        .triggerOutOne(triggerOutOne));

    pwm_trig_fault_partner i_pwm_trig_fault_partner (
        .clk(clk), .trigZero(triggerOutZero), .trigOne(triggerOutOne),
        .faultIn(faultIn));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    function automatic logic [31:0] mask_of(input logic [11:0] a);
        if (a == OFS_CTRL) return 32'h0000_007F;
        if (a == OFS_FILT) return 32'h0000_07FF;
        if (a == OFS_PERIOD) return 32'h0000_FFFF;
        if (a == OFS_SUB_BASE || a < OFS_SUB_BASE) return 32'h0000_0000;
        if (a[3:0] == SUB_ROUTE) return 32'h0000_000F;
        return 32'h0000_FFFF;
    endfunction : mask_of

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: reg got %h exp %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_num(input int got, input int exp);
        checks++;
        if (got != exp) begin
            fail_count++;
            $display("mismatch at %0t: got %0d exp %0d", $time, got, exp);
        end
    endtask : chk_num

    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdData = prdata;
        rdErr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        if (a != OFS_STATUS && a < 12'h050) mdl[a] = d & mask_of(a);
    endtask : wr

    task automatic rd_all;
        for (int a = 0; a < 'h54; a += 4) begin
            apb(1'b0, a[11:0], 32'h0);
            chk_reg(rdData, mdl.exists(a) ? mdl[a] : 32'h0);
            chk_reg({31'h0, rdErr}, {31'h0, !mdl.exists(a)});
        end
    endtask : rd_all

    // high cycles and longest high run of the masked pwm outputs
    task automatic watch(input int n, input logic [3:0] m, output int high,
                         output int maxRun);
        int run;
        high   = 0;
        maxRun = 0;
        run    = 0;
        repeat (n) begin
            @(posedge clk);
            if ((|(pwmOut & m)) !== 1'b0) begin
                high++;
                run++;
            end else run = 0;
            if (run > maxRun) maxRun = run;
        end
    endtask : watch

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            $display("mismatch at %0t: timeout", $time);
            wrap_up;
        end
    end

    initial begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; fail_count = 0; checks = 0;
        lfsrState = 16'h000F;
        for (int a = 0; a < 'h50; a += 4) mdl[a] = 32'h0;
        mdl[OFS_PERIOD] = {16'h0, RST_PERIOD};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_all;
        // random submodule settings, then an unmapped write
        for (int a = 'h10; a < 'h50; a += 4) begin
            lfsrState = lfsr(lfsrState);
            wr(a[11:0], {lfsrState, lfsrState});
        end
        wr(12'h050, 32'hFFFF_FFFF);
        rd_all;
        wr(OFS_PERIOD, 32'd15);
        for (int s = 0; s < 2; s++) begin
            wr(OFS_SUB_BASE + 12'h010 * s + SUB_CMPA, 32'd3);
            wr(OFS_SUB_BASE + 12'h010 * s + SUB_CMPB, 32'd11);
        end
        wr(12'h020, 32'd1);
        // trigger sources against a cmpA reference
        for (int s = 0; s < 4; s++) begin
            wr(OFS_SUB_BASE + SUB_ROUTE, {28'h0, SRC_CMPA, s[1:0]});
            wr(OFS_CTRL, 32'h1);
            repeat (40) @(posedge clk);
            chk_num(((i_pwm_trig_fault_partner.riseZero -
                      i_pwm_trig_fault_partner.riseOne) % 16 + 16) % 16,
                    offs[s]);
            chk_num(i_pwm_trig_fault_partner.widthZero, 1);
        end
        for (int p = 1; p < 4; p++) begin
            wr(OFS_CTRL, 32'h1 | (p << CTRL_PRSC_LO));
            repeat (40) @(posedge clk);
            chk_num(i_pwm_trig_fault_partner.widthZero, 1 << p);
        end
        // comb fault with and without glitch stretch
        for (int g = 0; g < 2; g++) begin
            wr(OFS_CTRL, 32'h1 | (g << CTRL_STRETCH));
            lfsrState = lfsr(lfsrState);
            i_pwm_trig_fault_partner.pulse(
                i_pwm_trig_fault_partner.legal_width(g[0], 0, 0)
                + lfsrState[1:0]);
            watch(48, 4'hF, hi, mr);
            chk_num(hi, 0);
            apb(1'b0, OFS_STATUS, 32'h0);
            chk_reg(rdData & 32'h0000_00F1, 32'h1);
            wr(OFS_STATUS, 32'h1);
            watch(32, 4'h1, hi, mr);
            chk_num(hi, 16);
        end
        // filtered path: a short pulse is rejected, a long one accepted
        wr(OFS_CTRL, 32'h5);
        wr(OFS_FILT, 32'h0000_0102);
        i_pwm_trig_fault_partner.pulse(3);
        repeat (30) @(posedge clk);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk_reg(rdData & 32'h1, 32'h0);
        i_pwm_trig_fault_partner.pulse(
            i_pwm_trig_fault_partner.legal_width(1'b0, 2, 1));
        repeat (30) @(posedge clk);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk_reg(rdData & 32'h1, 32'h1);
        wr(OFS_FILT, 32'h0);
        wr(OFS_STATUS, 32'h1);
        // phase delay lowered to zero under reload select
        wr(OFS_CTRL, 32'h3);
        wr(12'h020, 32'd5);
        repeat (40) @(posedge clk);
        wr(12'h020, 32'd0);
        watch(64, 4'h2, hi, mr);
        chk_num(mr, 8);
        // stop the counter so the status word reads back quiet
        wr(OFS_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        rd_all;
        wrap_up;
    end
endmodule : pwm_fault_phase_trigger_test
